// ==== adc_sequencer_control_tb.sv ====
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "adcsc_cfg.svh"
module adc_sequencer_control_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic rc_osc = 1'b0;
    logic rc_en = 1'b0;
    logic pready;
    logic pslverr;
    logic sample_hold;
    logic converter_power_on;
    logic cmp_above;
    logic [31:0] prdata;
    logic [3:0] ana_chan_sel;
    logic [9:0] dac_code;
    logic [10:0] samp = 11'h000;
    logic [10:0] lvl [16];
    logic [31:0] rdat;
    logic rerr;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int sh_cnt = 0;
    int sh_cyc [16];
    int b;

    adcsc_top DUT (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rc_osc(rc_osc), .cmp_above(cmp_above), .ana_chan_sel(ana_chan_sel), .sample_hold(sample_hold),
        .dac_code(dac_code), .converter_power_on(converter_power_on));

    always #10 clk = ~clk;
    // free rc source, phase unrelated to clk on purpose
    always #97 if (rc_en) rc_osc <= ~rc_osc;
    // 11-bit held level lets an input sit above full scale
    assign cmp_above = samp >= {1'b0, dac_code};

    // cycle count, pulse log and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sample_hold === 1'b1)
        begin
            sh_cyc[sh_cnt % 16] <= cyc;
            sh_cnt <= sh_cnt + 1;
        end
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    // held level is taken as the pulse rises, before the first bit trial compares against it
    always @(posedge sample_hold)
        samp <= lvl[ana_chan_sel];

    task print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk

    // one apb transfer, idle edge after it so strobes never toggle twice
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(what, exp, rdat);
    endtask : rd

    function automatic logic [7:0] slot(input int i);
        return `ADCSC_OFF_RES_FIRST + 8'(4 * i - 4);
    endfunction : slot

    task wait_done();
        rdat = 32'h0000_0000;
        while (rdat[7] !== 1'b1)
            apb(1'b0, `ADCSC_OFF_CTL, 32'h0000_0000);
    endtask : wait_done

    task t_regs();
        rd("control reset", `ADCSC_OFF_CTL, 32'h0000_0000);
        rd("option reset", `ADCSC_OFF_OPT, 32'h0000_0000);
        rd("rate reset", `ADCSC_OFF_RATE, 32'h0000_0000);
        for (int i = 1; i <= 8; i++)
            rd("slot reset", slot(i), 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0000_0000, rerr});
        apb(1'b1, slot(5), 32'hFFFF_FFFF);
        rd("slot write ignored", slot(5), 32'h0000_0000);
        apb(1'b1, `ADCSC_OFF_OPT, 32'h0000_0001);
        chk("power out", 32'h0000_0001, {31'h0000_0000, converter_power_on});
        repeat (5000) @(posedge clk); // bias settle time
        $display("test regs done");
    endtask : t_regs

    task t_single4();
        b = sh_cnt;
        apb(1'b1, `ADCSC_OFF_CTL, 32'h0000_0000);
        wait_done();
        rd("done flag", `ADCSC_OFF_CTL, 32'h0000_0080);
        for (int i = 5; i <= 8; i++)
            rd("saturated slot", slot(i), 32'h0000_FFC0);
        rd("slot one untouched", slot(1), 32'h0000_0000);
        repeat (100) @(posedge clk);
        chk("halt count", 32'(b + 4), 32'(sh_cnt));
        $display("test single4 done");
    endtask : t_single4

    task t_cont4();
        lvl[1] = 11'h155;
        b = sh_cnt;
        apb(1'b1, `ADCSC_OFF_CTL, 32'h0000_0021);
        wait_sh(b + 4);
        chk("mux code", 32'h0000_0001, {28'h000_0000, ana_chan_sel});
        lvl[1] = 11'h2AA;
        wait_sh(b + 6);
        rd("wrapped slot", slot(5), 32'h0000_AA80);
        rd("older slot", slot(6), 32'h0000_5540);
        chk("group time", 32'h0000_0090, 32'(sh_cyc[(b + 4) % 16] - sh_cyc[b % 16]));
        rd("flag in run", `ADCSC_OFF_CTL, 32'h0000_00A1);
        apb(1'b1, `ADCSC_OFF_CTL, 32'h0000_0021);
        rd("flag cleared", `ADCSC_OFF_CTL, 32'h0000_0021);
        apb(1'b1, `ADCSC_OFF_OPT, 32'h0000_0000);
        repeat (3) @(posedge clk);
        b = sh_cnt;
        repeat (200) @(posedge clk);
        chk("abort count", 32'(b), 32'(sh_cnt));
        $display("test cont4 done");
    endtask : t_cont4

    task wait_sh(input int n);
        while (sh_cnt < n)
            @(posedge clk);
    endtask : wait_sh

    task t_eight();
        apb(1'b1, `ADCSC_OFF_OPT, 32'h0000_0001);
        apb(1'b1, `ADCSC_OFF_RATE, 32'h0000_0001);
        b = sh_cnt;
        apb(1'b1, `ADCSC_OFF_CTL, 32'h0000_004C);
        wait_done();
        chk("eight count", 32'(b + 8), 32'(sh_cnt));
        chk("half time", 32'h0000_00D8, 32'(sh_cyc[(b + 3) % 16] - sh_cyc[b % 16]));
        for (int i = 1; i <= 8; i++)
            rd("eight slot", slot(i), 32'h0000_FFC0);
        $display("test eight done");
    endtask : t_eight

    task t_rc();
        apb(1'b1, `ADCSC_OFF_RATE, 32'h0000_0000);
        apb(1'b1, `ADCSC_OFF_OPT, 32'h0000_0003);
        rc_en = 1'b1;
        b = sh_cnt;
        apb(1'b1, `ADCSC_OFF_CTL, 32'h0000_000A);
        wait_sh(b + 1);
        chk("reserved mux", 32'h0000_000D, {28'h000_0000, ana_chan_sel});
        wait_done(); // poll instead of counting
        chk("rc count", 32'(b + 4), 32'(sh_cnt));
        chk("rc pace", 32'h0000_0001, 32'(sh_cyc[(b + 1) % 16] - sh_cyc[b % 16] > 300));
        for (int i = 5; i <= 8; i++)
            rd("reserved slot", slot(i), 32'h0000_0000);
        rc_en = 1'b0;
        $display("test rc done");
    endtask : t_rc

    initial
    begin
        for (int i = 0; i < 16; i++)
            lvl[i] = 11'h0C5;
        lvl[0] = 11'h5FF;
        lvl[12] = 11'h3FF;
        lvl[13] = 11'h000;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_single4();
        t_cont4();
        t_eight();
        t_rc();
        print_verdict();
    end
endmodule : adc_sequencer_control_tb

// ==== adcsc_cfg.svh ====
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef ADCSC_CFG_SVH
`define ADCSC_CFG_SVH

// register byte offsets on the apb bus
`define ADCSC_OFF_CTL 8'h00
`define ADCSC_OFF_OPT 8'h04
`define ADCSC_OFF_RATE 8'h08
`define ADCSC_OFF_RES_FIRST 8'h10
`define ADCSC_OFF_RES_LAST 8'h2C

// conv_control_status_reg fields
`define ADCSC_CTL_DONE_BIT 7
`define ADCSC_CTL_EIGHT_CONVERSION_SELECT_BIT 6
`define ADCSC_CTL_SCAN_BIT 5
`define ADCSC_CTL_GROUP_SCAN_SELECT_BIT 4
`define ADCSC_CTL_CHAN_MSB 3
`define ADCSC_CTL_CHAN_LSB 0
`define ADCSC_CTL_RST 7'h00

// option register fields
`define ADCSC_OPT_PWR_BIT 0
`define ADCSC_OPT_CONV_CLOCK_SOURCE_SELECT_BIT 1
// conv_rate_register field
`define ADCSC_RATE_HALF_BIT 0

// channel codes
`define ADCSC_CH_RSV_A 4'hA
`define ADCSC_CH_RSV_B 4'hB
`define ADCSC_CH_REF_LOW 4'hD

// result layout and slot use
`define ADCSC_RES_BITS 10
`define ADCSC_RES_PAD 6
`define ADCSC_SLOT_BASE4 3'h4
`define ADCSC_LAST_IDX4 3'h3
`define ADCSC_LAST_IDX8 3'h7

// conversion timing in conversion-clock ticks
`define ADCSC_GROUP_TICKS 144
`define ADCSC_CONVS_PER_GROUP 4
`define ADCSC_CONV_TICKS (`ADCSC_GROUP_TICKS / `ADCSC_CONVS_PER_GROUP)
`define ADCSC_SAMPLE_STEP 6'h00
`define ADCSC_LAST_BIT_STEP 6'h0A

`endif

// ==== adcsc_pkg.sv ====
// types shared by the converter sequencer modules
package adcsc_pkg;

    // sequencer states, one-hot
    typedef enum logic [1:0]
    {
        ADCSC_ST_IDLE = 2'b01,
        ADCSC_ST_RUN = 2'b10
    } adcsc_state_t;

    // one conversion result
    typedef logic [9:0] adcsc_res_t;

endpackage : adcsc_pkg

// ==== adcsc_sar.sv ====
// successive approximation engine: one sample, ten bit trials, fixed tick budget
`timescale 1ns/10ps
`include "adcsc_cfg.svh"
module adcsc_sar
    import adcsc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic cmp_above,
    output logic sample_hold,
    output adcsc_res_t dac_code,
    output logic done,
    output adcsc_res_t result
);

    logic busy_ff;
    logic [5:0] step_ff;
    adcsc_res_t trial_ff;
    logic sample_ff;
    logic [3:0] bit_idx;

    // bit under trial for steps 1..10
    assign bit_idx = 4'((`ADCSC_LAST_BIT_STEP) - step_ff);

    // step sequencing; start outranks abort so a restart is never lost
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_ff <= 1'b0;
            step_ff <= 6'h00;
            trial_ff <= 10'h000;
            sample_ff <= 1'b0;
        end
        else
        begin
            sample_ff <= 1'b0;
            if (start)
            begin
                busy_ff <= 1'b1;
                step_ff <= 6'h00;
                trial_ff <= 10'h200;
            end
            else if (abort)
                busy_ff <= 1'b0;
            else if (busy_ff && tick)
            begin
                step_ff <= step_ff + 6'h01;
                // hold the input once at the start of the conversion
                if (step_ff == `ADCSC_SAMPLE_STEP)
                    sample_ff <= 1'b1;
                else if (step_ff <= `ADCSC_LAST_BIT_STEP)
                begin
                    // keep or drop the trial bit, then try the next lower one
                    trial_ff[bit_idx] <= cmp_above;
                    if (bit_idx != 4'h0)
                        trial_ff[bit_idx - 4'h1] <= 1'b1;
                end
                // last tick: a restart from the top lands on this same edge, else the engine stops
                if (step_ff == 6'(`ADCSC_CONV_TICKS - 1))
                    busy_ff <= 1'b0;
            end
        end
    end

    assign sample_hold = sample_ff;
    assign dac_code = trial_ff;
    // done is combinational on the last tick so no idle cycle sits between conversions
    assign done = busy_ff & tick & (step_ff == 6'(`ADCSC_CONV_TICKS - 1));
    // all trials are settled long before the last tick
    assign result = trial_ff;

endmodule : adcsc_sar

// ==== adcsc_tick.sv ====
// conversion clock tick generator: e clock, e/2 or resynchronised rc oscillator
`timescale 1ns/10ps
`include "adcsc_cfg.svh"
module adcsc_tick
    import adcsc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_src_sel,
    input wire logic half_rate_select,
    input wire logic rc_osc,
    output logic tick
);

    logic rc_meta_ff;
    logic rc_sync_ff;
    logic rc_prev_ff;
    logic half_ff;

    // two-flop synchroniser; the first flop feeds only the second
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rc_meta_ff <= 1'b0;
            rc_sync_ff <= 1'b0;
            rc_prev_ff <= 1'b0;
        end
        else
        begin
            rc_meta_ff <= rc_osc;
            rc_sync_ff <= rc_meta_ff;
            rc_prev_ff <= rc_sync_ff;
        end
    end

    // divide-by-two phase for the half rate mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            half_ff <= 1'b0;
        else
            half_ff <= ~half_ff;
    end

    // rising rc edges become single e-clock ticks, so at most one step per e cycle
    always_comb
    begin
        if (clk_src_sel)
            tick = rc_sync_ff & ~rc_prev_ff;
        else if (half_rate_select)
            tick = half_ff;
        else
            tick = 1'b1;
    end

endmodule : adcsc_tick

// ==== adcsc_top.sv ====
// converter sequencer top: apb registers, sequencing, channel routing and result slots
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "adcsc_cfg.svh"
module adcsc_top
    import adcsc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic rc_osc,
    input wire logic cmp_above,
    output logic [3:0] ana_chan_sel,
    output logic sample_hold,
    output logic [9:0] dac_code,
    output logic converter_power_on
);

    // control, option and rate register fields
    logic [6:0] ctl_ff;
    logic seq_done_flag_ff;
    logic pwr_ff;
    logic conv_clock_source_select_ff;
    logic half_ff;

    // sequencer state
    adcsc_state_t state_ff;
    adcsc_state_t nxt_state;
    logic [2:0] idx_ff;
    logic [2:0] nxt_idx;
    logic [3:0] chan_ff;
    adcsc_res_t slot_ff [8];

    // apb read path
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    logic [31:0] rd_data;
    logic rd_hit;

    // strobes
    logic apb_setup;
    logic apb_wr;
    logic ctl_wr;
    logic opt_wr;
    logic rate_wr;
    logic seq_start;
    logic seq_abort;
    logic conv_start;
    logic pass_end;
    logic set_done;

    // engine hookup
    logic tick;
    logic sar_done;
    adcsc_res_t sar_result;

    // shorthand for mode bits
    logic eight_conversion_select;
    logic scan;
    logic group_scan_select;
    logic [3:0] chan_code;

    assign eight_conversion_select = ctl_ff[`ADCSC_CTL_EIGHT_CONVERSION_SELECT_BIT];
    assign scan = ctl_ff[`ADCSC_CTL_SCAN_BIT];
    assign group_scan_select = ctl_ff[`ADCSC_CTL_GROUP_SCAN_SELECT_BIT];
    assign chan_code = ctl_ff[`ADCSC_CTL_CHAN_MSB:`ADCSC_CTL_CHAN_LSB];

    // channel for conversion number idx; group scan walks the low code bits
    function automatic logic [3:0] conv_channel(
        input logic [3:0] code,
        input logic grp,
        input logic eight,
        input logic [2:0] idx
    );
        logic [3:0] raw;
        raw = code;
        if (grp && eight)
            raw = {code[3], idx};
        else if (grp)
            raw = {code[3:2], idx[1:0]};
        // reserved codes are wired to ref_low, giving a zero result
        if (raw == `ADCSC_CH_RSV_A || raw == `ADCSC_CH_RSV_B)
            raw = `ADCSC_CH_REF_LOW;
        return raw;
    endfunction : conv_channel

    // slot written by conversion number idx
    function automatic logic [2:0] slot_index(
        input logic eight,
        input logic [2:0] idx
    );
        if (eight)
            return idx;
        return `ADCSC_SLOT_BASE4 + {1'b0, idx[1:0]};
    endfunction : slot_index

    // last conversion number of a pass
    function automatic logic [2:0] last_index(
        input logic eight
    );
        return eight ? `ADCSC_LAST_IDX8 : `ADCSC_LAST_IDX4;
    endfunction : last_index

    // apb phases: read data is captured in setup, so access completes with no wait state
    assign apb_setup = psel & ~penable;
    assign pready = psel & penable;
    assign apb_wr = psel & penable & pwrite;
    assign ctl_wr = apb_wr && (paddr == `ADCSC_OFF_CTL);
    assign opt_wr = apb_wr && (paddr == `ADCSC_OFF_OPT);
    assign rate_wr = apb_wr && (paddr == `ADCSC_OFF_RATE);

    // a control write restarts while powered; power off only stops
    assign seq_start = ctl_wr & pwr_ff;
    assign seq_abort = ctl_wr | (opt_wr & ~pwdata[`ADCSC_OPT_PWR_BIT]) | ~pwr_ff;

    // end of a pass on the final conversion of the sequence
    assign pass_end = (state_ff == ADCSC_ST_RUN) && sar_done && (idx_ff == last_index(eight_conversion_select));
    assign set_done = pass_end & ~seq_abort;

    // engine start: new sequence, or the next conversion unless halting
    always_comb
    begin
        conv_start = 1'b0;
        if (seq_start)
            conv_start = 1'b1;
        else if (state_ff == ADCSC_ST_RUN && sar_done && !seq_abort)
            conv_start = !pass_end || scan;
    end

    // sequencer next state and conversion number
    always_comb
    begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        if (seq_start)
        begin
            nxt_state = ADCSC_ST_RUN;
            nxt_idx = 3'h0;
        end
        else if (seq_abort)
            nxt_state = ADCSC_ST_IDLE;
        else
        begin
            unique case (state_ff)
                ADCSC_ST_IDLE:
                begin
                    nxt_idx = idx_ff;
                end
                ADCSC_ST_RUN:
                begin
                    if (sar_done)
                    begin
                        if (!pass_end)
                            nxt_idx = idx_ff + 3'h1;
                        else if (scan)
                            nxt_idx = 3'h0;
                        else
                            nxt_state = ADCSC_ST_IDLE;
                    end
                end
                default:
                begin
                    nxt_state = ADCSC_ST_IDLE;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_ff <= ADCSC_ST_IDLE;
            idx_ff <= 3'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
        end
    end

    // channel latched at each conversion start, held through it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            chan_ff <= 4'h0;
        else if (seq_start)
            chan_ff <= conv_channel(pwdata[3:0], pwdata[`ADCSC_CTL_GROUP_SCAN_SELECT_BIT], pwdata[`ADCSC_CTL_EIGHT_CONVERSION_SELECT_BIT], 3'h0);
        else if (conv_start)
            chan_ff <= conv_channel(chan_code, group_scan_select, eight_conversion_select, nxt_idx);
    end

    assign ana_chan_sel = chan_ff;

    // control register; any write clears the done flag, and a pass end in the same cycle does not set it
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctl_ff <= `ADCSC_CTL_RST;
            seq_done_flag_ff <= 1'b0;
        end
        else
        begin
            if (ctl_wr)
                ctl_ff <= pwdata[6:0];
            if (set_done)
                seq_done_flag_ff <= 1'b1;
            else if (ctl_wr)
                seq_done_flag_ff <= 1'b0;
        end
    end

    // option and rate registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pwr_ff <= 1'b0;
            conv_clock_source_select_ff <= 1'b0;
            half_ff <= 1'b0;
        end
        else
        begin
            if (opt_wr)
            begin
                pwr_ff <= pwdata[`ADCSC_OPT_PWR_BIT];
                conv_clock_source_select_ff <= pwdata[`ADCSC_OPT_CONV_CLOCK_SOURCE_SELECT_BIT];
            end
            if (rate_wr)
                half_ff <= pwdata[`ADCSC_RATE_HALF_BIT];
        end
    end

    assign converter_power_on = pwr_ff;

    // result slots, written only from e-domain done pulses
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < 8; i++)
                slot_ff[i] <= 10'h000;
        end
        else if (state_ff == ADCSC_ST_RUN && sar_done && !seq_abort)
            slot_ff[slot_index(eight_conversion_select, idx_ff)] <= sar_result;
    end

    // read mux; unmapped offsets answer with an error and zero data
    always_comb
    begin
        rd_data = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == `ADCSC_OFF_CTL)
            rd_data[7:0] = {seq_done_flag_ff, ctl_ff};
        else if (paddr == `ADCSC_OFF_OPT)
            rd_data[1:0] = {conv_clock_source_select_ff, pwr_ff};
        else if (paddr == `ADCSC_OFF_RATE)
            rd_data[0] = half_ff;
        else if (paddr >= `ADCSC_OFF_RES_FIRST && paddr <= `ADCSC_OFF_RES_LAST && paddr[1:0] == 2'h0)
            // left-justified, low six bits zero
            rd_data[15:0] = {slot_ff[3'(paddr[4:2] - 3'h4)], `ADCSC_RES_PAD'h00};
        else
            rd_hit = 1'b0;
    end

    // read data and error captured in setup, stable through access
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
        else if (apb_setup)
        begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr_ff <= ~rd_hit;
        end
    end

    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff & pready;

    // conversion clock choice
    adcsc_tick u_tick
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .clk_src_sel(conv_clock_source_select_ff),
        .half_rate_select(half_ff),
        .rc_osc(rc_osc),
        .tick(tick)
    );

    // engine: a saturated input resolves to all ones, no overflow flag
    adcsc_sar u_sar
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(tick),
        .start(conv_start),
        .abort(seq_abort),
        .cmp_above(cmp_above),
        .sample_hold(sample_hold),
        .dac_code(dac_code),
        .done(sar_done),
        .result(sar_result)
    );

endmodule : adcsc_top

// ==== adcsc_top_monitor.sv ====
// port-level assertion checker for the converter sequencer top
`timescale 1ns/10ps
`include "adcsc_cfg.svh"
module adcsc_top_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic sample_hold,
    input wire logic [3:0] ana_chan_sel,
    input wire logic [9:0] dac_code,
    input wire logic converter_power_on
);
    logic acc;
    logic res_rd;
    logic mapped;
    // access phase and address map decode
    assign acc = psel && penable;
    assign res_rd = acc && !pwrite && paddr >= `ADCSC_OFF_RES_FIRST && paddr <= `ADCSC_OFF_RES_LAST;
    assign mapped = paddr[1:0] == 2'h0 && (paddr <= `ADCSC_OFF_RATE || res_rd || (acc && pwrite
        && paddr >= `ADCSC_OFF_RES_FIRST && paddr <= `ADCSC_OFF_RES_LAST));
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    rsv_chan_a: assert property (ana_chan_sel != `ADCSC_CH_RSV_A && ana_chan_sel != `ADCSC_CH_RSV_B)
        else $error("reserved code on mux select");
    res_pad_a: assert property (res_rd |-> prdata[5:0] == 6'h00)
        else $error("result low bits not zero");
    res_top_a: assert property (res_rd |-> prdata[31:16] == 16'h0000)
        else $error("result not within low half word");
    sample_once_a: assert property (sample_hold |=> !sample_hold [*8])
        else $error("sample pulse repeated inside a conversion");
    // first trial always sets the top code bit; power-off abort excused
    dac_first_a: assert property (disable iff (sys_rst || !converter_power_on)
        $rose(sample_hold) |-> dac_code == 10'h200)
        else $error("no top bit trial after sample");
    pwr_abort_a: assert property (!converter_power_on ##1 !converter_power_on |-> !sample_hold)
        else $error("sampling while powered off");
    pwr_bit_a: assert property (acc && pwrite && paddr == `ADCSC_OFF_OPT |=> converter_power_on == $past(pwdata[0]))
        else $error("power output does not follow write");
    pready_a: assert property (pready == acc)
        else $error("ready not in first access cycle");
    bad_addr_a: assert property (acc |-> pslverr == !mapped)
        else $error("slave error does not match address map");
endmodule : adcsc_top_monitor

bind adcsc_top adcsc_top_monitor mon (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sample_hold(sample_hold), .ana_chan_sel(ana_chan_sel), .dac_code(dac_code),
    .converter_power_on(converter_power_on));
